//--- hw/pias_consts.vh
// constants for the power-up init and address select block
// assumes a single core clock and decoded bus commands from a slave front end
`ifndef PIAS_CONSTS_VH
`define PIAS_CONSTS_VH

// ----------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------
`define PIAS_ST_WAIT 2'h0
`define PIAS_ST_LOAD 2'h1
`define PIAS_ST_ADDR 2'h2
`define PIAS_ST_RUN 2'h3

// ----------------------------------------------------------------
// command indexes of the working registers and the status and input-voltage reads
// ----------------------------------------------------------------
`define PIAS_IDX_I2C_BASE 8'h00
`define PIAS_IDX_PMBUS_BASE 8'h01
`define PIAS_IDX_ON_OFF 8'h02
`define PIAS_IDX_VIN_ON 8'h03
`define PIAS_IDX_VIN_OFF 8'h04
`define PIAS_IDX_VIN_OV 8'h05
`define PIAS_IDX_VIN_UV 8'h06
`define PIAS_IDX_STATUS 8'h0e
`define PIAS_IDX_READ_VIN 8'h10

// ----------------------------------------------------------------
// reset values, used until the load cycle overwrites them
// ----------------------------------------------------------------
`define PIAS_RST_I2C_BASE 8'h10
`define PIAS_RST_PMBUS_BASE 8'h40
`define PIAS_RST_ON_OFF 8'h00
`define PIAS_RST_VIN_ON 8'h20
`define PIAS_RST_VIN_OFF 8'h1c
`define PIAS_RST_VIN_OV 8'hff
`define PIAS_RST_VIN_UV 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PIAS_ONOFF_SW_SEL 0
`define PIAS_ONOFF_SW_ON 1
`define PIAS_ST_OV_BIT 0
`define PIAS_ST_UV_BIT 1

// ----------------------------------------------------------------
// offset decode of the address-select reading
// ----------------------------------------------------------------
`define PIAS_BAND_STEP 10'h03c
`define PIAS_FLOAT_LEVEL 10'h3c0

`endif

//--- hw/pias_top.v
// power-up sequencing, configuration load and bus-address selection
// assumes comparator, adc and store inputs synchronous to core_clk
// and a bus front end that presents one decoded command per pulse
//
// Operation
// [R1] hold power-on reset until rails, oscillator good
// [R2] copy every stored word into working registers
// [R3] accept writes after load regardless of enable
// [R4] convert only on enable, undervoltage_lockout, load, address
// [R5] software enable may override the pin condition
// [R6] separate 7-bit i2c and pmbus base addresses
// [R7] base address zero silences that interface
// [R8] resistor offset of sixteen steps on both bases
// [R9] sample offset voltage once during initialization
// [R10] sixteen ordered bands map to offsets 0..15
// [R11] digital mode answers reads, writes at address
// [R12] floating select pin enters analog mode
// [R13] analog mode keeps loaded configuration frozen
// [R14] bus undervoltage_lockout default 1 V, host-adjustable levels
// [R15] digitized input voltage only for readback
// [R16] lockout, fault, warning come from comparators
// [R17] effective address is base plus latched offset
// [R18] ignore bus until load and offset done

`include "pias_consts.vh"

module pias_top #(
  parameter CFG_WORDS = 7,
  parameter ADC_W = 10
) (
  input wire core_clk,
  input wire rst_n,
  // supply and oscillator monitors
  input wire vcc_good,
  input wire core_logic_rail_good,
  input wire osc_stable,
  // nonvolatile configuration store, data valid with ack
  output reg nvm_rd_q,
  output reg [7:0] nvm_addr_q,
  input wire nvm_ack,
  input wire [7:0] nvm_data,
  // address-select adc conversion
  output reg adc_start_q,
  input wire adc_done,
  input wire [ADC_W-1:0] adc_data,
  // input-voltage telemetry adc
  input wire [ADC_W-1:0] vin_adc_data,
  // comparators
  input wire enable_input_pin,
  input wire vin_above_on,
  input wire vin_below_off,
  input wire vin_above_ov,
  input wire vin_below_uv,
  // decoded bus commands
  input wire bus_req,
  input wire bus_sel_pmbus,
  input wire [6:0] bus_addr,
  input wire bus_write,
  input wire [7:0] bus_cmd,
  input wire [7:0] bus_wdata,
  output reg bus_ack_q,
  output reg [15:0] bus_rdata_q,
  // status and control outputs
  output reg por_n_q,
  output reg init_done_q,
  output reg analog_mode_q,
  output reg [3:0] addr_offset_q,
  output reg [6:0] i2c_eff_addr_q,
  output reg [6:0] pmbus_eff_addr_q,
  output reg undervoltage_lockout_ok_q,
  output reg vin_ov_fault_q,
  output reg vin_uv_warn_q,
  output reg conv_en_q,
  output reg [7:0] vin_on_level_q,
  output reg [7:0] vin_off_level_q,
  output reg [7:0] vin_ov_level_q,
  output reg [7:0] vin_uv_level_q
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg [1:0] state_q;
  reg [7:0] cfg_q [0:CFG_WORDS-1];
  reg [1:0] sticky_q;
  reg [1:0] sticky_d;
  wire [14:0] above;
  reg [3:0] band;
  wire floating;
  wire por_ok;
  wire run;
  wire i2c_hit;
  wire pmbus_hit;
  wire hit;
  wire wr_hit;
  wire load_wr;
  wire sw_sel;
  wire sw_on;
  wire pin_cond;
  reg [15:0] rd_d;
  integer j;
  integer m;

  // ----------------------------------------------------------------
  // power-on reset and sequencer
  // ----------------------------------------------------------------
  assign por_ok = vcc_good & core_logic_rail_good & osc_stable; // [R1]
  assign run = (state_q == `PIAS_ST_RUN);
  assign load_wr = (state_q == `PIAS_ST_LOAD) & nvm_ack;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= `PIAS_ST_WAIT;
      por_n_q <= 1'b0;
      nvm_rd_q <= 1'b0;
      nvm_addr_q <= 8'h00;
      adc_start_q <= 1'b0;
      init_done_q <= 1'b0;
      analog_mode_q <= 1'b0;
      addr_offset_q <= 4'h0;
      i2c_eff_addr_q <= 7'h00;
      pmbus_eff_addr_q <= 7'h00;
    end else if (!por_ok) begin
      // rail drop restarts the whole initialization
      state_q <= `PIAS_ST_WAIT; // [R1]
      por_n_q <= 1'b0;
      nvm_rd_q <= 1'b0;
      nvm_addr_q <= 8'h00;
      adc_start_q <= 1'b0;
      init_done_q <= 1'b0;
      analog_mode_q <= 1'b0;
    end else begin
      por_n_q <= 1'b1;
      adc_start_q <= 1'b0;
      case (state_q)
        `PIAS_ST_WAIT: begin
          state_q <= `PIAS_ST_LOAD; // [R2]
          nvm_rd_q <= 1'b1;
          nvm_addr_q <= 8'h00;
        end
        `PIAS_ST_LOAD: begin
          if (nvm_ack) begin
            if (nvm_addr_q == CFG_WORDS[7:0] - 8'h01) begin
              nvm_rd_q <= 1'b0;
              state_q <= `PIAS_ST_ADDR;
              adc_start_q <= 1'b1; // [R9]
            end else begin
              nvm_addr_q <= nvm_addr_q + 8'h01; // [R2]
            end
          end
        end
        `PIAS_ST_ADDR: begin
          // single conversion per initialization; later changes on the pin are seen only after a restart
          if (adc_done) begin
            analog_mode_q <= floating; // [R12]
            addr_offset_q <= band; // [R9]
            i2c_eff_addr_q <= cfg_q[0][6:0] + {3'h0, band}; // [R17] [R8]
            pmbus_eff_addr_q <= cfg_q[1][6:0] + {3'h0, band}; // [R17] [R8]
            init_done_q <= 1'b1;
            state_q <= `PIAS_ST_RUN;
          end
        end
        `PIAS_ST_RUN: begin
          state_q <= `PIAS_ST_RUN;
        end
        default: begin
          state_q <= `PIAS_ST_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // offset band decode
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < 15; k = k + 1) begin : g_band
      localparam [ADC_W-1:0] THR = `PIAS_BAND_STEP * (k + 1);
      assign above[k] = (adc_data >= THR); // [R10]
    end
  endgenerate

  // thresholds are ordered, so the count of exceeded ones is the band
  always @* begin
    band = 4'h0;
    for (j = 0; j < 15; j = j + 1) begin
      band = band + {3'h0, above[j]}; // [R10]
    end
  end

  // open pin pulls to the top of the range
  assign floating = (adc_data >= `PIAS_FLOAT_LEVEL); // [R12]

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // digital mode only, after load and offset read
  assign i2c_hit = !bus_sel_pmbus & (cfg_q[0][6:0] != 7'h00) & (bus_addr == i2c_eff_addr_q); // [R7] [R6]
  assign pmbus_hit = bus_sel_pmbus & (cfg_q[1][6:0] != 7'h00) & (bus_addr == pmbus_eff_addr_q); // [R7] [R6]
  assign hit = bus_req & run & !analog_mode_q & (i2c_hit | pmbus_hit); // [R18] [R12] [R11]
  // enable state plays no part in write acceptance
  assign wr_hit = hit & bus_write; // [R3] [R13]

  // ----------------------------------------------------------------
  // working configuration registers
  // ----------------------------------------------------------------
  function [7:0] rst_val;
    input integer idx;
    begin
      case (idx)
        0: rst_val = `PIAS_RST_I2C_BASE;
        1: rst_val = `PIAS_RST_PMBUS_BASE;
        2: rst_val = `PIAS_RST_ON_OFF;
        3: rst_val = `PIAS_RST_VIN_ON;
        4: rst_val = `PIAS_RST_VIN_OFF;
        5: rst_val = `PIAS_RST_VIN_OV;
        6: rst_val = `PIAS_RST_VIN_UV;
        default: rst_val = 8'h00;
      endcase
    end
  endfunction

  genvar w;
  generate
    for (w = 0; w < CFG_WORDS; w = w + 1) begin : g_cfg
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_q[w] <= rst_val(w);
        end else if (load_wr && nvm_addr_q == w[7:0]) begin
          cfg_q[w] <= nvm_data; // [R2]
        end else if (wr_hit && bus_cmd == w[7:0]) begin
          cfg_q[w] <= bus_wdata; // [R3] [R11] [R14]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // comparator thresholds
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vin_on_level_q <= `PIAS_RST_VIN_ON;
      vin_off_level_q <= `PIAS_RST_VIN_OFF;
      vin_ov_level_q <= `PIAS_RST_VIN_OV;
      vin_uv_level_q <= `PIAS_RST_VIN_UV;
    end else begin
      vin_on_level_q <= cfg_q[3]; // [R14] [R16]
      vin_off_level_q <= cfg_q[4]; // [R14] [R16]
      vin_ov_level_q <= cfg_q[5]; // [R16]
      vin_uv_level_q <= cfg_q[6]; // [R16]
    end
  end

  // ----------------------------------------------------------------
  // lockout, fault and warning from comparators
  // ----------------------------------------------------------------
  // telemetry reading is deliberately absent from all of these
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      undervoltage_lockout_ok_q <= 1'b0;
      vin_ov_fault_q <= 1'b0;
      vin_uv_warn_q <= 1'b0;
    end else begin
      if (vin_above_on) begin
        undervoltage_lockout_ok_q <= 1'b1; // [R16] [R15]
      end else if (vin_below_off) begin
        undervoltage_lockout_ok_q <= 1'b0; // [R16] [R15]
      end
      vin_ov_fault_q <= vin_above_ov; // [R16]
      vin_uv_warn_q <= vin_below_uv; // [R16]
    end
  end

  // sticky copies for software; a new event beats a clear
  always @* begin
    sticky_d = sticky_q;
    if (wr_hit && bus_cmd == `PIAS_IDX_STATUS) begin
      sticky_d = sticky_q & ~bus_wdata[1:0];
    end
    if (vin_ov_fault_q) begin
      sticky_d[`PIAS_ST_OV_BIT] = 1'b1;
    end
    if (vin_uv_warn_q) begin
      sticky_d[`PIAS_ST_UV_BIT] = 1'b1;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sticky_q <= 2'h0;
    end else if (!run) begin
      sticky_q <= 2'h0;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  // ----------------------------------------------------------------
  // power conversion enable
  // ----------------------------------------------------------------
  // software selection only reachable from the bus in digital mode
  assign sw_sel = cfg_q[2][`PIAS_ONOFF_SW_SEL] & !analog_mode_q; // [R5]
  assign sw_on = cfg_q[2][`PIAS_ONOFF_SW_ON];
  assign pin_cond = sw_sel ? sw_on : enable_input_pin; // [R5] [R4]

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_en_q <= 1'b0;
    end else begin
      conv_en_q <= run & init_done_q & undervoltage_lockout_ok_q & pin_cond; // [R4]
    end
  end

  // ----------------------------------------------------------------
  // read data and acknowledge
  // ----------------------------------------------------------------
  always @* begin
    rd_d = 16'h0000;
    if (bus_cmd == `PIAS_IDX_READ_VIN) begin
      rd_d = {{(16 - ADC_W){1'b0}}, vin_adc_data}; // [R15]
    end else if (bus_cmd == `PIAS_IDX_STATUS) begin
      rd_d = {6'h00, addr_offset_q, conv_en_q, undervoltage_lockout_ok_q, 2'h0, sticky_q};
    end else begin
      for (m = 0; m < CFG_WORDS; m = m + 1) begin
        if (bus_cmd == m[7:0]) begin
          rd_d = {8'h00, cfg_q[m]}; // [R11]
        end
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack_q <= 1'b0;
      bus_rdata_q <= 16'h0000;
    end else begin
      bus_ack_q <= hit; // [R18] [R11]
      if (hit && !bus_write) begin
        bus_rdata_q <= rd_d; // [R11]
      end
    end
  end

endmodule // pias_top

//--- tb/pias_chk_sva.sv
// assertions on the power-up init and address select top
// assumes adc_data is held steady by the bench across a conversion
module pias_chk #(
  parameter ADC_W = 10
) (
  input wire core_clk,
  input wire rst_n,
  input wire vcc_good,
  input wire core_logic_rail_good,
  input wire osc_stable,
  input wire nvm_rd_q,
  input wire [7:0] nvm_addr_q,
  input wire nvm_ack,
  input wire adc_start_q,
  input wire [ADC_W-1:0] adc_data,
  input wire vin_above_ov,
  input wire vin_below_uv,
  input wire bus_ack_q,
  input wire por_n_q,
  input wire init_done_q,
  input wire analog_mode_q,
  input wire [3:0] addr_offset_q,
  input wire undervoltage_lockout_ok_q,
  input wire vin_ov_fault_q,
  input wire vin_uv_warn_q,
  input wire conv_en_q
);
  timeunit 1ns;
  timeprecision 1ns;
  wire por_ok = vcc_good && core_logic_rail_good && osc_stable;
  wire [ADC_W-1:0] quot = ADC_W'(adc_data / 60);
  // readings past the last band clamp to offset 15
  wire [3:0] band = (quot > 15) ? 4'hf : quot[3:0];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  chk_por_hold: assert property (!por_ok |=> !por_n_q)
    else $error("power-on reset released with a monitor low");
  chk_load_start: assert property ($rose(por_n_q) |-> nvm_rd_q && nvm_addr_q == 8'h00)
    else $error("load did not start at word zero");
  chk_adc_after: assert property (por_ok && nvm_rd_q && nvm_ack && nvm_addr_q == 8'h06 |=> adc_start_q && !nvm_rd_q)
    else $error("offset conversion not started after last word");
  chk_mode_pick: assert property ($rose(init_done_q) |-> analog_mode_q == (adc_data >= 960))
    else $error("mode does not match select reading");
  chk_band_map: assert property ($rose(init_done_q) && !analog_mode_q |-> addr_offset_q == band)
    else $error("offset band wrong");
  chk_conv_gate: assert property (conv_en_q |-> $past(undervoltage_lockout_ok_q) && $past(init_done_q))
    else $error("conversion enabled without lockout or init");
  chk_ack_gate: assert property (bus_ack_q |-> $past(init_done_q) && !$past(analog_mode_q))
    else $error("bus answered before init or in analog mode");
  chk_comp_track: assert property ($past(rst_n) |-> vin_ov_fault_q == $past(vin_above_ov)
    && vin_uv_warn_q == $past(vin_below_uv))
    else $error("fault or warning does not follow comparator");
  cover property ($rose(init_done_q) && analog_mode_q);
  cover property (bus_ack_q);
  cover property (conv_en_q);
endmodule // pias_chk

bind pias_top pias_chk #(.ADC_W(ADC_W)) u_chk (.core_clk, .rst_n, .vcc_good, .core_logic_rail_good,
  .osc_stable, .nvm_rd_q, .nvm_addr_q, .nvm_ack, .adc_start_q, .adc_data, .vin_above_ov, .vin_below_uv,
  .bus_ack_q, .por_n_q, .init_done_q, .analog_mode_q, .addr_offset_q, .undervoltage_lockout_ok_q, .vin_ov_fault_q,
  .vin_uv_warn_q, .conv_en_q);

//--- tb/pias_host.sv
// host model issuing decoded bus commands
// assumes one request pulse per command and an ack in the following cycle
module pias_host (
  input logic core_clk,
  input logic bus_ack_q,
  input logic [15:0] bus_rdata_q,
  output logic bus_req,
  output logic bus_sel_pmbus,
  output logic [6:0] bus_addr,
  output logic bus_write,
  output logic [7:0] bus_cmd,
  output logic [7:0] bus_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {bus_req, bus_sel_pmbus, bus_write} = 3'h0;
    {bus_addr, bus_cmd, bus_wdata} = 23'h0;
  end
  // the host may select software enable through a write of the on/off word
  task automatic xfer(input logic s, input logic [6:0] a, input logic w, input logic [7:0] c, input logic [7:0] d,
    output logic ack, output logic [15:0] rd);
    @(posedge core_clk);
    #10;
    {bus_sel_pmbus, bus_addr, bus_write, bus_cmd, bus_wdata} = {s, a, w, c, d};
    bus_req = 1;
    @(posedge core_clk);
    #10;
    bus_req = 0;
    // released address and write-data lines show a changed value, not the last one
    bus_addr = ~a;
    bus_wdata = ~d;
    ack = bus_ack_q;
    rd = bus_rdata_q;
    // one idle cycle keeps requests apart; a late ack counts as none
    @(posedge core_clk);
    #10;
  endtask
endmodule // pias_host

//--- tb/powerup_init_address_select_tb.sv
// self-checking bench for power-up init and address select
// assumes store and adc answer at once; host model drives the bus
module powerup_init_address_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0;
  logic rst_n = 0, vcc_good = 1, core_logic_rail_good = 1, osc_stable = 0;
  logic nvm_ack = 0, adc_done = 0, enable_input_pin = 0;
  logic vin_above_on = 0, vin_below_off = 0, vin_above_ov = 0, vin_below_uv = 0;
  logic [7:0] nvm_data = 8'h00;
  logic [9:0] adc_data = 10'h000, vin_adc_data = 10'h000;
  logic bus_req, bus_sel_pmbus, bus_write, bus_ack_q, nvm_rd_q, adc_start_q, ack;
  logic [6:0] bus_addr, i2c_eff_addr_q, pmbus_eff_addr_q;
  logic [7:0] bus_cmd, bus_wdata, nvm_addr_q, vin_on_level_q, vin_off_level_q, vin_ov_level_q, vin_uv_level_q;
  logic [15:0] bus_rdata_q, rd;
  logic por_n_q, init_done_q, analog_mode_q, undervoltage_lockout_ok_q, conv_en_q, vin_ov_fault_q, vin_uv_warn_q;
  logic [3:0] addr_offset_q;
  logic [7:0] mdl [8];
  int num_errors = 0, checked = 0, cycles = 0;

  pias_top dut (.core_clk, .rst_n, .vcc_good, .core_logic_rail_good, .osc_stable, .nvm_rd_q, .nvm_addr_q,
    .nvm_ack, .nvm_data, .adc_start_q, .adc_done, .adc_data, .vin_adc_data, .enable_input_pin, .vin_above_on,
    .vin_below_off, .vin_above_ov, .vin_below_uv, .bus_req, .bus_sel_pmbus, .bus_addr, .bus_write, .bus_cmd,
    .bus_wdata, .bus_ack_q, .bus_rdata_q, .por_n_q, .init_done_q, .analog_mode_q, .addr_offset_q,
    .i2c_eff_addr_q, .pmbus_eff_addr_q, .undervoltage_lockout_ok_q, .vin_ov_fault_q, .vin_uv_warn_q, .conv_en_q,
    .vin_on_level_q, .vin_off_level_q, .vin_ov_level_q, .vin_uv_level_q);
  pias_host h (.core_clk, .bus_ack_q, .bus_rdata_q, .bus_req, .bus_sel_pmbus, .bus_addr, .bus_write,
    .bus_cmd, .bus_wdata);

  always #50 core_clk = ~core_clk;

  // store and adc models answer in the same cycle as each request
  always @(posedge core_clk) begin
    #10;
    nvm_ack = nvm_rd_q;
    nvm_data = nvm_rd_q ? mdl[nvm_addr_q[2:0]] : ~nvm_data;
    adc_done = adc_start_q;
    {vin_above_ov, vin_below_uv} = 2'($urandom);
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      results();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bx(input logic s, input logic [6:0] a, input logic w, input logic [7:0] c, input logic [7:0] d);
    h.xfer(s, a, w, c, d, ack, rd);
  endtask
  task automatic boot(input logic [9:0] a, input logic an, input logic [3:0] k);
    rst_n = 0;
    osc_stable = 0;
    adc_data = a;
    cyc(16);
    rst_n = 1;
    cyc(3);
    chk({15'h0, por_n_q}, 16'h0000);
    osc_stable = 1;
    // a command in mid-load must be ignored
    bx(0, 7'h10, 1, 8'h03, 8'h5a);
    chk({15'h0, ack}, 16'h0000);
    for (int i = 0; i < 40 && init_done_q !== 1'b1; i++) cyc(1);
    chk({15'h0, init_done_q}, 16'h0001);
    chk({15'h0, analog_mode_q}, {15'h0, an});
    chk({8'h0, vin_on_level_q}, {8'h0, mdl[3]});
    chk({vin_off_level_q, vin_ov_level_q}, {mdl[4], mdl[5]});
    chk({8'h0, vin_uv_level_q}, {8'h0, mdl[6]});
    if (!an) begin
      chk({12'h0, addr_offset_q}, {12'h0, k});
      chk({9'h0, i2c_eff_addr_q}, {9'h0, 7'h10 + 7'(k)});
      chk({9'h0, pmbus_eff_addr_q}, {9'h0, 7'h40 + 7'(k)});
    end
  endtask

  initial begin
    void'($urandom(32'h789559cb));
    foreach (mdl[i]) mdl[i] = 8'($urandom);
    mdl[0] = 8'h10;
    mdl[1] = 8'h40;
    mdl[2] = 8'h00;
    vin_adc_data = 10'($urandom);
    for (int k = 0; k < 16; k++) begin
      boot(10'(60 * k + $urandom_range(0, 59)), 0, 4'(k));
      mdl[3] = 8'($urandom);
      bx(0, i2c_eff_addr_q, 1, 8'h03, mdl[3]);
      chk({15'h0, ack}, 16'h0001);
      bx(1, pmbus_eff_addr_q, 0, 8'h03, 8'h00);
      chk(rd, {8'h0, mdl[3]});
      chk({8'h0, vin_on_level_q}, {8'h0, mdl[3]});
    end
    bx(0, i2c_eff_addr_q + 7'h01, 1, 8'h03, 8'h00);
    chk({15'h0, ack}, 16'h0000);
    bx(1, pmbus_eff_addr_q, 0, 8'h10, 8'h00);
    chk(rd, {6'h0, vin_adc_data});
    vin_above_on = 1;
    enable_input_pin = 1;
    cyc(3);
    chk({15'h0, conv_en_q}, 16'h0001);
    enable_input_pin = 0;
    cyc(3);
    chk({15'h0, conv_en_q}, 16'h0000);
    bx(0, i2c_eff_addr_q, 1, 8'h02, 8'h03);
    cyc(2);
    chk({15'h0, conv_en_q}, 16'h0001);
    vin_above_on = 0;
    vin_below_off = 1;
    cyc(3);
    chk({15'h0, conv_en_q}, 16'h0000);
    // comparators toggle at random every cycle, so both sticky flags are set by now
    bx(1, pmbus_eff_addr_q, 0, 8'h0e, 8'h00);
    chk(rd, 16'h03c3);
    bx(0, i2c_eff_addr_q, 1, 8'h00, 8'h00);
    bx(0, i2c_eff_addr_q, 1, 8'h03, 8'h00);
    chk({15'h0, ack}, 16'h0000);
    bx(1, pmbus_eff_addr_q, 0, 8'h00, 8'h00);
    chk(rd, 16'h0000);
    boot(10'h3c0 + 10'($urandom_range(0, 63)), 1, 4'h0);
    bx(0, i2c_eff_addr_q, 1, 8'h03, ~mdl[3]);
    chk({15'h0, ack}, 16'h0000);
    chk({8'h0, vin_on_level_q}, {8'h0, mdl[3]});
    // a drop of either rail restarts the whole initialization
    core_logic_rail_good = 0;
    cyc(2);
    chk({14'h0, por_n_q, init_done_q}, 16'h0000);
    core_logic_rail_good = 1;
    vcc_good = 0;
    cyc(2);
    chk({15'h0, por_n_q}, 16'h0000);
    vcc_good = 1;
    for (int i = 0; i < 40 && init_done_q !== 1'b1; i++) cyc(1);
    chk({14'h0, por_n_q, init_done_q}, 16'h0003);
    results();
  end
endmodule // powerup_init_address_select_tb
